// *** src/scpm_ctrl.sv ***
`timescale 1ns/1ps
module scpm_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic power_down_pin_n_i,
  input wire logic gen2_enable_i,
  input wire logic is_master_i,
  input wire logic slot0_start_i,
  input wire logic slave_frame_sync_in_i,
  input wire logic wr_i,
  input wire logic [5:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_i,
  input wire logic [5:0] rd_addr_i,
  input wire logic slot1_i,
  input wire logic [15:0] gen3_rate_i,
  output logic [15:0] rd_data_o,
  output logic [15:0] slot1_data_o,
  output logic slot1_valid_o,
  output logic phase_step_o,
  output logic phase_retard_o,
  output logic gen3_use_sync_o,
  output logic gen3_video_o,
  output logic gen3_bitclk_en_o,
  output logic gen3_phase_shift_en_o,
  output logic gen3_eight_sevenths_o,
  output logic gen3_bitclk_plus200_o,
  output logic gen3_loop_gain_o,
  output logic gen3_conv_x128_o,
  output logic [7:0] gen3_rate_modifiers_o,
  output logic [15:0] gen3_rate_o,
  output logic gen3_rate_ok_o
);
  typedef struct packed {
    logic [2:0] pd_sync;
    logic [2:0] fs_sync;
    logic [15:0] phase;
    logic [15:0] mode;
    logic [15:0] snap;
    logic [15:0] rd_data;
    logic [15:0] pend;
    logic pend_v;
    logic [15:0] slot1;
    logic slot1_v;
    logic step;
    logic retard;
    logic use_sync;
    logic video;
    logic bitclk_en;
    logic ph_en;
    logic x87;
    logic p200;
    logic gain;
    logic c128;
    logic [7:0] rmod;
    logic [15:0] rate;
    logic rate_ok;
  } scpm_st_t;
  scpm_st_t s_r;
  scpm_st_t s_nxt;
  logic step_tick;
  logic ph_hold;
  logic frame_mark;
  logic [7:0] mag;
  logic ref_sync;
  logic vid;
  assign mag = s_r.phase[scpm_pkg::MAG_W-1:0];
  // pin levels resynchronised; only stage 1 and 2 are read by logic
  assign ph_hold = !s_r.pd_sync[1] || !gen2_enable_i;
  assign frame_mark = is_master_i ? slot0_start_i
                    : (s_r.fs_sync[1] && !s_r.fs_sync[2]);
  assign ref_sync = s_r.mode[scpm_pkg::G3_REF_BIT];
  // video bit has no meaning on crystal reference
  assign vid = ref_sync && s_r.mode[scpm_pkg::G3_VID_BIT];
  scpm_step_gen u_step (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(ce_i),
    .run_i(mag != 8'h00 && !ph_hold),
    .step_o(step_tick)
  );
  always_comb begin
    s_nxt = s_r;
    s_nxt.pd_sync = {s_r.pd_sync[1:0], power_down_pin_n_i};
    s_nxt.fs_sync = {s_r.fs_sync[1:0], slave_frame_sync_in_i};
    s_nxt.step = 1'b0;
    if (step_tick && mag != 8'h00) begin
      s_nxt.phase[scpm_pkg::MAG_W-1:0] = mag - 8'h01;
      s_nxt.step = 1'b1;
    end
    if (frame_mark) begin
      s_nxt.snap = s_r.phase;
      if (s_r.pend_v) begin
        s_nxt.slot1 = s_r.pend;
        s_nxt.slot1_v = 1'b1;
        s_nxt.pend_v = 1'b0;
      end else begin
        s_nxt.slot1_v = 1'b0;
      end
    end
    if (slot1_i) begin
      s_nxt.slot1_v = 1'b0;
    end
    if (wr_i) begin
      if (wr_addr_i == scpm_pkg::ADDR_GEN2_PHASE) begin
        s_nxt.pend = s_r.phase;
        s_nxt.pend_v = 1'b1;
        if (!ph_hold) begin
          // reserved bits dropped; host should send zero there anyway
          s_nxt.phase = wr_data_i & scpm_pkg::GEN2_PHASE_MASK;
        end
      end else if (wr_addr_i == scpm_pkg::ADDR_GEN3_MODE) begin
        s_nxt.pend = s_r.mode;
        s_nxt.pend_v = 1'b1;
        s_nxt.mode = wr_data_i & scpm_pkg::GEN3_MODE_MASK;
      end
    end
    if (ph_hold) begin
      s_nxt.phase = scpm_pkg::GEN2_PHASE_RST;
    end
    if (rd_i) begin
      if (rd_addr_i == scpm_pkg::ADDR_GEN2_PHASE) begin
        s_nxt.rd_data = s_r.snap;
      end else if (rd_addr_i == scpm_pkg::ADDR_GEN3_MODE) begin
        s_nxt.rd_data = s_r.mode;
      end else begin
        s_nxt.rd_data = 16'h0000;
      end
    end
    s_nxt.retard = s_r.phase[scpm_pkg::PH_DIR_BIT];
    s_nxt.use_sync = ref_sync;
    s_nxt.video = vid;
    s_nxt.bitclk_en = !vid;
    s_nxt.ph_en = !ref_sync;
    s_nxt.x87 = !ref_sync && s_r.mode[scpm_pkg::G3_X87_BIT];
    s_nxt.p200 = !vid && s_r.mode[scpm_pkg::G3_P200_BIT];
    s_nxt.gain = s_r.mode[scpm_pkg::G3_GAIN_BIT];
    s_nxt.c128 = s_r.mode[scpm_pkg::G3_C128_BIT];
    s_nxt.rmod = s_r.mode[scpm_pkg::G3_RATE_MSB:0];
    s_nxt.rate = ref_sync ? 16'h0000 : gen3_rate_i;
    s_nxt.rate_ok = !ref_sync && gen3_rate_i >= scpm_pkg::RATE_MIN
                    && gen3_rate_i <= scpm_pkg::RATE_MAX;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
  assign rd_data_o = s_r.rd_data;
  assign slot1_data_o = s_r.slot1;
  assign slot1_valid_o = s_r.slot1_v;
  assign phase_step_o = s_r.step;
  assign phase_retard_o = s_r.retard;
  assign gen3_use_sync_o = s_r.use_sync;
  assign gen3_video_o = s_r.video;
  assign gen3_bitclk_en_o = s_r.bitclk_en;
  assign gen3_phase_shift_en_o = s_r.ph_en;
  assign gen3_eight_sevenths_o = s_r.x87;
  assign gen3_bitclk_plus200_o = s_r.p200;
  assign gen3_loop_gain_o = s_r.gain;
  assign gen3_conv_x128_o = s_r.c128;
  assign gen3_rate_modifiers_o = s_r.rmod;
  assign gen3_rate_o = s_r.rate;
  assign gen3_rate_ok_o = s_r.rate_ok;
endmodule : scpm_ctrl

// *** src/scpm_pkg.sv ***
package scpm_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] ADDR_GEN2_PHASE = 6'h15;
  localparam logic [5:0] ADDR_GEN3_MODE = 6'h16;
  localparam logic [15:0] GEN2_PHASE_RST = 16'h0000;
  localparam logic [15:0] GEN3_MODE_RST = 16'h0000;
  localparam logic [15:0] GEN2_PHASE_MASK = 16'h01FF;
  localparam logic [15:0] GEN3_MODE_MASK = 16'hFCFF;
  localparam int unsigned PH_DIR_BIT = 8;
  localparam int unsigned MAG_W = 8;
  localparam int unsigned G3_REF_BIT = 15;
  localparam int unsigned G3_VID_BIT = 14;
  localparam int unsigned G3_GAIN_BIT = 13;
  localparam int unsigned G3_P200_BIT = 12;
  localparam int unsigned G3_X87_BIT = 11;
  localparam int unsigned G3_C128_BIT = 10;
  localparam int unsigned G3_RATE_MSB = 7;
  // phase unit, millidegrees per lsb
  localparam int unsigned PHASE_LSB_MDEG = 120;
  localparam int unsigned MCLK_KHZ = 24576;
  localparam int unsigned STEP_KHZ = 3072;
  localparam int unsigned STEP_DIV = MCLK_KHZ / STEP_KHZ;
  localparam logic [2:0] STEP_LAST = 3'(STEP_DIV - 1);
  localparam logic [15:0] RATE_MIN = 16'h0FA0;
  localparam logic [15:0] RATE_MAX = 16'hD2F0;
endpackage : scpm_pkg

// *** src/scpm_step_gen.sv ***
`timescale 1ns/1ps
// divides the master clock by eight to pace phase processing
module scpm_step_gen (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic run_i,
  output logic step_o
);
  typedef struct packed {
    logic [2:0] cnt;
    logic step;
  } scpm_step_st_t;
  scpm_step_st_t s_r;
  scpm_step_st_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.step = 1'b0;
    if (!run_i) begin
      s_nxt.cnt = 3'h0;
    end else if (s_r.cnt == scpm_pkg::STEP_LAST) begin
      s_nxt.cnt = 3'h0;
      s_nxt.step = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 3'h1;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else if (en_i) begin
      s_r <= s_nxt;
    end
  end
  assign step_o = s_r.step;
endmodule : scpm_step_gen

// *** dv/scpm_chk.sv ***
`timescale 1ns/1ps
module scpm_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic rd_i,
  input wire logic [5:0] rd_addr_i,
  input wire logic [15:0] rd_data_o,
  input wire logic phase_step_o,
  input wire logic gen3_use_sync_o,
  input wire logic gen3_video_o,
  input wire logic gen3_bitclk_en_o,
  input wire logic gen3_phase_shift_en_o,
  input wire logic gen3_eight_sevenths_o,
  input wire logic [15:0] gen3_rate_o,
  input wire logic gen3_rate_ok_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rd_hold_a: assert property (!(ce_i && rd_i) |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  rd_unmap_a: assert property (ce_i && rd_i && rd_addr_i != 6'h15 &&
    rd_addr_i != 6'h16 |=> rd_data_o == 16'h0000)
    else $error("unmapped read not zero");
  rd_resv_a: assert property (ce_i && rd_i && rd_addr_i == 6'h15
    |=> rd_data_o[15:9] == 7'h00)
    else $error("phase read shows reserved bits");
  // ce is held high, a frozen pulse would trip this
  step_gap_a: assert property (phase_step_o |=> !phase_step_o [*7])
    else $error("phase steps closer than eight cycles");
  sync_phase_a: assert property (gen3_use_sync_o
    |-> !gen3_phase_shift_en_o && !gen3_eight_sevenths_o)
    else $error("sync reference still shifts or scales");
  sync_rate_a: assert property (gen3_use_sync_o
    |-> gen3_rate_o == 16'h0000)
    else $error("sync reference uses rate register");
  video_bit_a: assert property (gen3_use_sync_o && gen3_video_o
    |-> !gen3_bitclk_en_o)
    else $error("bit clock on in video lock");
  rate_ok_a: assert property (gen3_rate_ok_o |-> !gen3_use_sync_o &&
    gen3_rate_o >= scpm_pkg::RATE_MIN && gen3_rate_o <= scpm_pkg::RATE_MAX)
    else $error("rate flagged usable out of range");
  cover property (phase_step_o);
  cover property (gen3_use_sync_o && gen3_video_o);
  cover property (gen3_rate_ok_o);
endmodule : scpm_chk
bind scpm_ctrl scpm_chk i_scpm_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .ce_i(ce_i), .rd_i(rd_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
  .phase_step_o(phase_step_o), .gen3_use_sync_o(gen3_use_sync_o),
  .gen3_video_o(gen3_video_o), .gen3_bitclk_en_o(gen3_bitclk_en_o),
  .gen3_phase_shift_en_o(gen3_phase_shift_en_o),
  .gen3_eight_sevenths_o(gen3_eight_sevenths_o),
  .gen3_rate_o(gen3_rate_o), .gen3_rate_ok_o(gen3_rate_ok_o));

// *** dv/scpm_dsp_model.sv ***
`timescale 1ns/1ps
// serial port master: one frame mark, slot 1 four cycles later
module scpm_dsp_model #(parameter int FRAME = 16) (
  input wire logic clk_i,
  output logic slot0_o = 1'b0,
  output logic slot1_o = 1'b0
);
  int n = 0;
  always @(negedge clk_i) begin
    n <= (n == FRAME - 1) ? 0 : n + 1;
    slot0_o <= (n == 0);
    slot1_o <= (n == 4);
  end
endmodule : scpm_dsp_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, resetn_i = 1'b0, pd_n = 1'b1, en2 = 1'b1;
  logic wr = 1'b0, rd = 1'b0, s0, s1, sv, stp, ret, us, vid, bce, pse;
  logic x87, c128, ok;
  logic ms = 1'b1, fs = 1'b0;
  logic [5:0] wa = 6'h00, ra = 6'h00;
  logic [7:0] rm;
  logic [15:0] wd = 16'h0000, rate = 16'hBB80, rdat, sdat, rout;
  int bad_count = 0, compares = 0, c;
  always #25 clk_i = ~clk_i;
  scpm_dsp_model i_scpm_dsp_model (.clk_i(clk_i), .slot0_o(s0), .slot1_o(s1));
  scpm_ctrl i_scpm_ctrl (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .power_down_pin_n_i(pd_n), .gen2_enable_i(en2), .is_master_i(ms),
    .slot0_start_i(s0), .slave_frame_sync_in_i(fs), .wr_i(wr),
    .wr_addr_i(wa), .wr_data_i(wd), .rd_i(rd), .rd_addr_i(ra),
    .slot1_i(s1), .gen3_rate_i(rate), .rd_data_o(rdat),
    .slot1_data_o(sdat), .slot1_valid_o(sv), .phase_step_o(stp),
    .phase_retard_o(ret), .gen3_use_sync_o(us), .gen3_video_o(vid),
    .gen3_bitclk_en_o(bce), .gen3_phase_shift_en_o(pse),
    .gen3_eight_sevenths_o(x87), .gen3_bitclk_plus200_o(),
    .gen3_loop_gain_o(), .gen3_conv_x128_o(c128),
    .gen3_rate_modifiers_o(rm), .gen3_rate_o(rout), .gen3_rate_ok_o(ok));
  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc
  task automatic wt(ref logic s);
    for (int i = 0; s !== 1'b1; i++) begin
      if (i > 200) begin
        bad_count++;
        close_out();
      end else begin
        cyc(1);
      end
    end
  endtask : wt
  task automatic wrt(input logic [5:0] a, input logic [15:0] d);
    wa = a; wd = d; wr = 1'b1; cyc(1); wr = 1'b0;
  endtask : wrt
  task automatic rdx(input logic [5:0] a);
    ra = a; rd = 1'b1; cyc(1); rd = 1'b0; cyc(1);
  endtask : rdx
  // pulses sampled just after each edge so each is counted once
  task automatic cnt(input int k);
    c = 0;
    repeat (k) begin
      @(posedge clk_i);
      #1 c += int'(stp);
    end
  endtask : cnt
  task automatic t_reset;
    rdx(6'h15); chk(rdat, 16'h0000);
    rdx(6'h16); chk(rdat, 16'h0000);
    rdx(6'h3F); chk(rdat, 16'h0000);
    $display("done t_reset");
  endtask : t_reset
  task automatic t_step;
    wrt(6'h15, 16'h0103); cnt(40);
    chk(16'(ret), 16'h0001);
    chk(16'(c), 16'h0003);
    cyc(1); wa = 6'h15; wd = 16'h00FF; wr = 1'b1; cyc(1);
    wd = 16'h0002; cyc(1); wr = 1'b0; cnt(40);
    chk(16'(c), 16'h0002);
    chk(16'(ret), 16'h0000);
    $display("done t_step");
  endtask : t_step
  task automatic t_hold;
    for (int i = 0; i < 2; i++) begin
      {pd_n, en2} = (i == 0) ? 2'b10 : 2'b01; cyc(4);
      wrt(6'h15, 16'h0105); cnt(30);
      chk(16'(c), 16'h0000);
      cyc(1); wt(s0); cyc(4); rdx(6'h15); chk(rdat, 16'h0000);
      {pd_n, en2} = 2'b11; cyc(20);
    end
    $display("done t_hold");
  endtask : t_hold
  task automatic t_mode;
    wrt(6'h16, 16'h8F5A); cyc(2);
    chk(16'({us, pse, x87, c128}), 16'h0009);
    chk(16'(rm), 16'h005A); chk(rout, 16'h0000);
    rdx(6'h16); chk(rdat, 16'h8C5A);
    wt(sv); chk(sdat, 16'h0000); cyc(8);
    wrt(6'h16, 16'hC000); cyc(2); chk(16'({vid, bce}), 16'h0002);
    wt(sv); chk(sdat, 16'h8C5A); cyc(8);
    wrt(6'h16, 16'h0800); cyc(2);
    chk(16'({pse, x87, ok}), 16'h0007); chk(rout, 16'hBB80);
    rate = 16'hD2F1; cyc(3); chk(16'(ok), 16'h0000);
    rate = 16'h0FA0; cyc(3); chk(16'(ok), 16'h0001);
    $display("done t_mode");
  endtask : t_mode
  // zero magnitude keeps the value still, so the snapshot is exact
  task automatic t_slave;
    ms = 1'b0; wrt(6'h15, 16'h0100); cyc(40);
    rdx(6'h15); chk(rdat, 16'h0000);
    fs = 1'b1; cyc(6); fs = 1'b0; cyc(2);
    rdx(6'h15); chk(rdat, 16'h0100);
    $display("done t_slave");
  endtask : t_slave
  initial begin
    cyc(4); resetn_i = 1'b1; cyc(4);
    t_reset(); t_step(); t_hold(); t_mode(); t_slave();
    close_out();
  end
endmodule : testbench
